// [bblpc_pkg.sv]
// package: register map, reset values, field layout and decode constants of the brownout/low-power bank
package bblpc_pkg;
	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] BBLPC_ADDR_BUCK1_BO = 8'h49;
	localparam logic [7:0] BBLPC_ADDR_BUCK2_BO = 8'h4D;
	localparam logic [7:0] BBLPC_ADDR_BUCK3_BO = 8'h51;
	localparam logic [7:0] BBLPC_ADDR_LP_VOLT = 8'h52;
	localparam logic [7:0] BBLPC_RDATA_UNMAPPED = 8'h00;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] BBLPC_RST_BUCK1_BO = 8'h49;
	localparam logic [7:0] BBLPC_RST_BUCK2_BO = 8'h49;
	localparam logic [7:0] BBLPC_RST_BUCK3_BO = 8'h59;
	localparam logic [7:0] BBLPC_RST_LP_VOLT = 8'h37;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int BBLPC_BO_THR_HI = 3;
	localparam int BBLPC_BO_THR_LO = 2;
	localparam int BBLPC_BO_HYS_HI = 1;
	localparam int BBLPC_BO_HYS_LO = 0;
	localparam int BBLPC_BO_BLANK_HI = 7;
	localparam int BBLPC_BO_BLANK_LO = 4;
	localparam int BBLPC_LP_RSVD_BIT = 7;
	localparam int BBLPC_LP_CODE_HI = 6;
	localparam int BBLPC_LP_CODE_LO = 0;

	// ----------------------------------------------------------------
	// decode tables, in percent of the output voltage setting
	// ----------------------------------------------------------------
	localparam logic [6:0] BBLPC_THR_PCT_0 = 7'd77;
	localparam logic [6:0] BBLPC_THR_PCT_1 = 7'd81;
	localparam logic [6:0] BBLPC_THR_PCT_2 = 7'd86;
	localparam logic [6:0] BBLPC_THR_PCT_3 = 7'd91;
	localparam logic [4:0] BBLPC_HYS_PCT_0 = 5'd5;
	localparam logic [4:0] BBLPC_HYS_PCT_1 = 5'd10;
	localparam logic [4:0] BBLPC_HYS_PCT_2 = 5'd15;
	localparam logic [4:0] BBLPC_HYS_PCT_3 = 5'd20;

	// low-power target: code 1 is 260 mV, 10 mV per code, code 127 is 1520 mV
	localparam logic [10:0] BBLPC_LP_MV_MIN = 11'd260;
	localparam logic [10:0] BBLPC_LP_MV_STEP = 11'd10;
	localparam logic [6:0] BBLPC_LP_CODE_FIRST = 7'h01;
	localparam logic [6:0] BBLPC_LP_CODE_RSVD = 7'h00;
	localparam int BBLPC_NUM_BUCK = 3;
	localparam int BBLPC_THR_PCT_W = 7;
	localparam int BBLPC_HYS_PCT_W = 5;
endpackage

// [bblpc_regs.sv]
// module: brownout threshold/hysteresis bank for three bucks plus low-power voltage of the third buck
// register map: 0x49, 0x4D and 0x51 hold brownout settings of bucks 1 to 3
// 0x52 holds the low-power voltage code of buck 3; other addresses read zero
// writes to unmapped addresses are dropped without a trace
// brownout byte: [7:4] no flops, [3:2] falling threshold, [1:0] hysteresis
// low-power byte: [7] reserved but kept, [6:0] low-power voltage code
// decoded outputs trail a register write by one edge more than the register
// mode pin is asynchronous and passes two flops; target and flag switch together
// reserved code 0 is stored as written; its mV target clamps to the lowest step, but the target code in low-power mode stays 0
// limitation: the target output is a code select, conversion to volts lies elsewhere
`timescale 1ns/1ps
`default_nettype none
module bblpc_regs
	import bblpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic lowpower_mode_pin,
	input wire logic [7:0] output_voltage_setting,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	output logic [20:0] brownout_fall_threshold_pct_q,
	output logic [14:0] brownout_hysteresis_pct_q,
	output logic [10:0] lowpower_target_mv_q,
	output logic lowpower_active_q,
	output logic [7:0] buck3_target_code_q
);

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	// threshold code to percent of the output voltage setting
	function automatic logic [6:0] bblpc_thr_pct(input logic [1:0] code);
		case (code)
			2'h0: bblpc_thr_pct = BBLPC_THR_PCT_0;
			2'h1: bblpc_thr_pct = BBLPC_THR_PCT_1;
			2'h2: bblpc_thr_pct = BBLPC_THR_PCT_2;
			default: bblpc_thr_pct = BBLPC_THR_PCT_3;
		endcase
	endfunction

	// hysteresis code to percent of the output voltage setting
	function automatic logic [4:0] bblpc_hys_pct(input logic [1:0] code);
		case (code)
			2'h0: bblpc_hys_pct = BBLPC_HYS_PCT_0;
			2'h1: bblpc_hys_pct = BBLPC_HYS_PCT_1;
			2'h2: bblpc_hys_pct = BBLPC_HYS_PCT_2;
			default: bblpc_hys_pct = BBLPC_HYS_PCT_3;
		endcase
	endfunction

	// reserved code 0 is clamped to the floor so the target never drops below 0.26V
	function automatic logic [10:0] bblpc_lp_mv(input logic [6:0] code);
		logic [6:0] eff;
		logic [10:0] steps;
		eff = (code == BBLPC_LP_CODE_RSVD) ? BBLPC_LP_CODE_FIRST : code;
		steps = 11'(eff - BBLPC_LP_CODE_FIRST);
		bblpc_lp_mv = 11'(BBLPC_LP_MV_MIN + 11'(steps * BBLPC_LP_MV_STEP));
	endfunction

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [3:0] bo_cfg_q [BBLPC_NUM_BUCK];
	logic [7:0] lp_volt_q;

	// mode pin synchroniser stages
	logic lp_sync1_q;
	logic lp_sync2_q;

	// next values of the read byte and of the third buck's target code
	logic [7:0] rdata_d;
	logic [7:0] buck3_target_d;

	// only the low nibble of each brownout register has flops; the top nibble is fixed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_cfg_q[0] <= BBLPC_RST_BUCK1_BO[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
			bo_cfg_q[1] <= BBLPC_RST_BUCK2_BO[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
			bo_cfg_q[2] <= BBLPC_RST_BUCK3_BO[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
		end else if (reg_wr_en) begin
			case (reg_addr)
				BBLPC_ADDR_BUCK1_BO: bo_cfg_q[0] <= reg_wdata[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
				BBLPC_ADDR_BUCK2_BO: bo_cfg_q[1] <= reg_wdata[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
				BBLPC_ADDR_BUCK3_BO: bo_cfg_q[2] <= reg_wdata[BBLPC_BO_THR_HI:BBLPC_BO_HYS_LO];
				default: ;
			endcase
		end
	end

	// whole byte stored, reserved bit included; code 0 is accepted but software must avoid it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_volt_q <= BBLPC_RST_LP_VOLT;
		end else if (reg_wr_en && (reg_addr == BBLPC_ADDR_LP_VOLT)) begin
			lp_volt_q <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// read data is registered: one cycle latency, unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			BBLPC_ADDR_BUCK1_BO: rdata_d = {BBLPC_RST_BUCK1_BO[BBLPC_BO_BLANK_HI:BBLPC_BO_BLANK_LO], bo_cfg_q[0]};
			BBLPC_ADDR_BUCK2_BO: rdata_d = {BBLPC_RST_BUCK2_BO[BBLPC_BO_BLANK_HI:BBLPC_BO_BLANK_LO], bo_cfg_q[1]};
			BBLPC_ADDR_BUCK3_BO: rdata_d = {BBLPC_RST_BUCK3_BO[BBLPC_BO_BLANK_HI:BBLPC_BO_BLANK_LO], bo_cfg_q[2]};
			BBLPC_ADDR_LP_VOLT: rdata_d = lp_volt_q;
			default: rdata_d = BBLPC_RDATA_UNMAPPED;
		endcase
	end

	// read byte is captured only on a read so it stands until the next one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= BBLPC_RDATA_UNMAPPED;
		end else if (reg_rd_en) begin
			reg_rdata_q <= rdata_d;
		end
	end

	// valid is a one-cycle echo of the read strobe, unmapped reads included
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd_en;
		end
	end

	// ----------------------------------------------------------------
	// brownout decode outputs
	// ----------------------------------------------------------------
	// threshold percent per buck; registered so the comparator never sees a decode glitch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brownout_fall_threshold_pct_q <= '0;
		end else begin
			for (int i = 0; i < BBLPC_NUM_BUCK; i++) begin
				brownout_fall_threshold_pct_q[i*BBLPC_THR_PCT_W +: BBLPC_THR_PCT_W] <=
					bblpc_thr_pct(bo_cfg_q[i][BBLPC_BO_THR_HI:BBLPC_BO_THR_LO]);
			end
		end
	end

	// hysteresis percent per buck, same timing as the threshold
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brownout_hysteresis_pct_q <= '0;
		end else begin
			for (int i = 0; i < BBLPC_NUM_BUCK; i++) begin
				brownout_hysteresis_pct_q[i*BBLPC_HYS_PCT_W +: BBLPC_HYS_PCT_W] <=
					bblpc_hys_pct(bo_cfg_q[i][BBLPC_BO_HYS_HI:BBLPC_BO_HYS_LO]);
			end
		end
	end

	// ----------------------------------------------------------------
	// low-power mode selection for the third buck
	// ----------------------------------------------------------------
	// mode pin is asynchronous to clk, two flops before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_sync1_q <= 1'b0;
			lp_sync2_q <= 1'b0;
		end else begin
			lp_sync1_q <= lowpower_mode_pin;
			lp_sync2_q <= lp_sync1_q;
		end
	end

	// low-power target follows the field in any mode, so it is ready before entry
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowpower_target_mv_q <= '0;
		end else begin
			lowpower_target_mv_q <= bblpc_lp_mv(lp_volt_q[BBLPC_LP_CODE_HI:BBLPC_LP_CODE_LO]);
		end
	end

	// mode flag mirrors the second sync stage, in step with the target code
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lowpower_active_q <= 1'b0;
		end else begin
			lowpower_active_q <= lp_sync2_q;
		end
	end

	// next target code: low-power field in low-power mode, else the normal setting
	always_comb begin
		if (lp_sync2_q) begin
			buck3_target_d = {1'b0, lp_volt_q[BBLPC_LP_CODE_HI:BBLPC_LP_CODE_LO]};
		end else begin
			buck3_target_d = output_voltage_setting;
		end
	end

	// target code changes on the same edge as the mode flag, never one apart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buck3_target_code_q <= '0;
		end else begin
			buck3_target_code_q <= buck3_target_d;
		end
	end

endmodule // bblpc_regs
`default_nettype wire

// [bblpc_monitor.sv]
// checker: timing and decode relations at the bank's ports
`timescale 1ns/1ps
`default_nettype none
module bblpc_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic lowpower_mode_pin,
	input wire logic [7:0] output_voltage_setting,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire logic [20:0] brownout_fall_threshold_pct_q,
	input wire logic [14:0] brownout_hysteresis_pct_q,
	input wire logic [10:0] lowpower_target_mv_q,
	input wire logic lowpower_active_q,
	input wire logic [7:0] buck3_target_code_q
);
	localparam logic [6:0] THR [4] = '{7'h4D, 7'h51, 7'h56, 7'h5B};
	localparam logic [4:0] HYS [4] = '{5'h05, 5'h0A, 5'h0F, 5'h14};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// decode outputs trail a write by two edges: register, then table
	rd_pulse_a: assert property (reg_rvalid_q == $past(reg_rd_en)) else $error("rvalid timing");
	blank_lo_a: assert property (reg_rd_en && reg_addr == 8'h49 |=> reg_rdata_q[7:4] == 4'h4)
		else $error("buck1 blank bits");
	blank_hi_a: assert property (reg_rd_en && reg_addr == 8'h51 |=> reg_rdata_q[7:4] == 4'h5)
		else $error("buck3 blank bits");
	thr_decode_a: assert property (reg_wr_en && reg_addr == 8'h49 |-> ##2
		brownout_fall_threshold_pct_q[6:0] == THR[$past(reg_wdata[3:2], 2)]) else $error("threshold decode");
	hys_decode_a: assert property (reg_wr_en && reg_addr == 8'h51 |-> ##2
		brownout_hysteresis_pct_q[14:10] == HYS[$past(reg_wdata[1:0], 2)]) else $error("hysteresis decode");
	lp_mv_a: assert property (reg_wr_en && reg_addr == 8'h52 && reg_wdata[6:0] != 7'h00 |-> ##2
		lowpower_target_mv_q == 11'h0FA + 11'h00A * {4'h0, $past(reg_wdata[6:0], 2)}) else $error("lp mv");
	lp_sync_a: assert property ($rose(lowpower_mode_pin) |-> ##3 lowpower_active_q) else $error("lp sync");
	norm_sel_a: assert property ($past(rst_n) && !lowpower_active_q && !$past(lowpower_active_q) |->
		buck3_target_code_q == $past(output_voltage_setting)) else $error("normal target");
	cover property ($rose(lowpower_active_q));
	cover property (reg_wr_en && reg_addr == 8'h52);
	cover property (reg_rd_en && reg_addr == 8'h51);
endmodule // bblpc_monitor
`default_nettype wire

// [bblpc_host.sv]
// host model: single-byte register strobes toward the bank
`timescale 1ns/1ps
`default_nettype none
module bblpc_host (
	input wire logic clk,
	output logic wr,
	output logic rd,
	output logic [7:0] addr,
	output logic [7:0] wdata
);
	initial {wr, rd, addr, wdata} = 18'h0;
	// one strobe cycle; lines then flip so a stale byte never looks valid
	// codes software should avoid arrive only when the bench asks for them
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{wr, rd, addr, wdata} = {w, !w, a, d};
		@(negedge clk);
		{wr, rd, addr, wdata} = {2'b00, ~a, ~d};
	endtask
endmodule // bblpc_host
`default_nettype wire

// [buck_brownout_lowpower_cfg_tb_top.sv]
// testbench: reset table, field decode, low-power target select
`timescale 1ns/1ps
`default_nettype none
module buck_brownout_lowpower_cfg_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, wr, rd, rv, act;
	logic [7:0] addr, wd, rdq, tgt, code, ovs = 8'h00;
	logic [31:0] lf = 32'h46DC;
	logic [20:0] thr;
	logic [14:0] hys;
	logic [10:0] mv;
	logic [7:0] q[$];
	int miscompares = 0, n_checks = 0, cyc = 0;
	localparam logic [7:0] AD [4] = '{8'h49, 8'h4D, 8'h51, 8'h52};
	localparam logic [7:0] RST [4] = '{8'h49, 8'h49, 8'h59, 8'h37};
	localparam logic [6:0] THR [4] = '{7'h4D, 7'h51, 7'h56, 7'h5B};
	localparam logic [4:0] HYS [4] = '{5'h05, 5'h0A, 5'h0F, 5'h14};
	initial forever #50 clk = ~clk;
	bblpc_host h (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wd));
	bblpc_regs uut (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd),
		.lowpower_mode_pin(pin), .output_voltage_setting(ovs), .reg_rdata_q(rdq), .reg_rvalid_q(rv),
		.brownout_fall_threshold_pct_q(thr), .brownout_hysteresis_pct_q(hys), .lowpower_target_mv_q(mv),
		.lowpower_active_q(act), .buck3_target_code_q(tgt));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		h.acc(1'b0, a, 8'h00);
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// returned bytes against the oldest note, looked at on the falling edge where they have settled
	always @(negedge clk) begin
		cyc++;
		if (rv) chk({3'h0, rdq}, q.size() != 0 ? {3'h0, q.pop_front()} : 11'hXXX);
		if (cyc == 1000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) rdx(AD[i], RST[i]);
		rdx(8'h4A, 8'h00);
		// every threshold and hysteresis code on each buck, blank bits written as zero
		for (int b = 0; b < 3; b++) begin
			for (int k = 0; k < 4; k++) begin
				lf = nxt(lf);
				h.acc(1'b1, AD[b], {4'h0, 2'(k), 2'(3 - k)});
				rdx(AD[b], {RST[b][7:4], 2'(k), 2'(3 - k)});
				chk(11'(thr[7 * b +: 7]), 11'(THR[k]));
				chk(11'(hys[5 * b +: 5]), 11'(HYS[3 - k]));
			end
		end
		// production setting on buck1 picks the loosest code, prototype screening on buck3 the tighter one
		h.acc(1'b1, AD[0], 8'h01);
		h.acc(1'b1, AD[2], 8'h08);
		@(negedge clk);
		chk(11'(thr[6:0]), 11'(THR[0]));
		chk(11'(thr[20:14]), 11'(THR[2]));
		for (int i = 0; i < 3; i++) begin
			lf = nxt(lf);
			code = (i == 0) ? 8'h01 : (i == 1) ? 8'h7F : ((lf[7:0] & 8'h7F) | 8'h01);
			h.acc(1'b1, 8'h52, code);
			rdx(8'h52, code);
			chk(mv, 11'h0FA + 11'h00A * {4'h0, code[6:0]});
		end
		ovs = lf[15:8];
		pin = 1'b1;
		repeat (5) @(negedge clk);
		chk({3'h0, tgt}, {4'h0, code[6:0]});
		chk({10'h000, act}, 11'h001);
		pin = 1'b0;
		repeat (5) @(negedge clk);
		chk({3'h0, tgt}, {3'h0, ovs});
		chk({10'h000, act}, 11'h000);
		conclude;
	end
endmodule // buck_brownout_lowpower_cfg_tb_top
bind bblpc_regs bblpc_monitor mon (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .lowpower_mode_pin(lowpower_mode_pin),
	.output_voltage_setting(output_voltage_setting), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
	.brownout_fall_threshold_pct_q(brownout_fall_threshold_pct_q),
	.brownout_hysteresis_pct_q(brownout_hysteresis_pct_q), .lowpower_target_mv_q(lowpower_target_mv_q),
	.lowpower_active_q(lowpower_active_q), .buck3_target_code_q(buck3_target_code_q));
`default_nettype wire
